// ===== rtl/hfo_fan_regs.sv
// Index/data register access for the monitor and the two fan drive outputs.
// Assumes host I/O cycles arrive as one-cycle read/write strobes on ref_clk,
// and the strap pin is asynchronous to ref_clk.
// Limitation: the automatic control modes are decoded only; no loop runs here.
`timescale 1ns/1ns
module hfo_fan_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Base address configuration
  input wire logic [7:0] base_high_byte_cfg,
  input wire logic [7:0] base_low_byte_cfg,
  // Host I/O cycle
  input wire hfo_pkg::hfo_io_req_t io_req,
  output logic io_hit,
  output logic [7:0] io_rdata,
  // Strap that sets the output value reset level
  input wire logic [7:0] fan_set_strap,
  // Fan drives
  output logic system_fan_drive,
  output logic processor_fan_drive,
  output logic [5:0] system_fan_dc_level,
  output logic [5:0] processor_fan_dc_level,
  output logic system_drive_is_dc,
  output logic processor_drive_is_dc,
  // Mode fields for the automatic control logic, and the bank select
  output hfo_pkg::hfo_mode_t system_drive_mode_field,
  output hfo_pkg::hfo_mode_t processor_drive_mode_field,
  output logic [7:0] bank_select
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // The frequency registers are split into clock select and divider fields
  // by their packed type, so the channels below never slice them by number.
  logic [6:0] index_pointer;
  logic [7:0] bank;
  hfo_pkg::hfo_freq_t sys_fan_pwm_freq;
  hfo_pkg::hfo_freq_t cpu_fan_pwm_freq;
  logic [7:0] sys_fan_output_value;
  logic [7:0] cpu_fan_output_value;
  logic [7:0] fan_config_one;
  logic [7:0] sys_target_temp_speed;
  logic [7:0] cpu_target_temp_speed;
  logic [15:0] base_addr;
  logic hit_index;
  logic hit_data;
  logic data_wr;
  logic [7:0] next_rdata;

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  logic [7:0] strap_s1;
  logic [7:0] strap_s2;
  logic [7:0] strap_s3;
  logic strap_loaded;

  // The strap is off-domain; three stages, taken only when the last two agree.
  always_ff @(posedge ref_clk) begin
    strap_s1 <= fan_set_strap;
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
  end

  // Reset may not load a port value, so the strap is loaded once after release.
  // The load waits for two agreeing stages, so a strap that is still moving
  // at release delays the load by a cycle instead of capturing a half value.
  // The strap is never sampled again until the next reset.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strap_loaded <= 1'b0;
    end else if (strap_s2 == strap_s3) begin
      strap_loaded <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Host decode
  // ----------------------------------------------------------------
  // The base comes from configuration logic on this clock, so it is used as is.
  // Both ports compare all sixteen address bits; aliases never answer.
  // io_hit is combinational so that the host cycle can be claimed at once.
  assign base_addr = {base_high_byte_cfg, base_low_byte_cfg};
  assign hit_index = (io_req.addr == base_addr + hfo_pkg::PORT_INDEX_OFS);
  assign hit_data = (io_req.addr == base_addr + hfo_pkg::PORT_DATA_OFS);
  assign io_hit = (io_req.rd | io_req.wr) & (hit_index | hit_data);
  assign data_wr = io_req.wr & hit_data;

  // Returns true when the pointer reaches a global index.
  function automatic logic is_global(input logic [6:0] idx);
    is_global = (idx <= hfo_pkg::IDX_GLOBAL_LAST);
  endfunction : is_global

  // Pointer keeps only bits 6:0; bit 7 is dropped on write.
  // Indexes 80h-FFh cannot be reached, so they need no decode.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      index_pointer <= 7'h00;
    end else if (io_req.wr && hit_index) begin
      index_pointer <= io_req.wdata[6:0];
    end
  end

  // Bank select register.
  // All implemented indexes are global, so the bank only reads back here
  // and is offered to the banked register files outside this block.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bank <= hfo_pkg::BANK_RESET;
    end else if (data_wr && index_pointer == hfo_pkg::IDX_BANK_SEL) begin
      bank <= io_req.wdata;
    end
  end
  assign bank_select = bank;

  // Bank 0 fan registers; all sit below 50h so every bank reaches them.
  // Config bits 7:6 are masked on write and on read, so they always read zero.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sys_fan_pwm_freq <= hfo_pkg::FREQ_RESET;
      cpu_fan_pwm_freq <= hfo_pkg::FREQ_RESET;
      fan_config_one <= hfo_pkg::FAN_CFG_RESET;
      sys_target_temp_speed <= hfo_pkg::ZERO_BYTE;
      cpu_target_temp_speed <= hfo_pkg::ZERO_BYTE;
    end else if (data_wr && is_global(index_pointer)) begin
      case (index_pointer)
        hfo_pkg::IDX_SYS_FREQ: sys_fan_pwm_freq <= io_req.wdata;
        hfo_pkg::IDX_CPU_FREQ: cpu_fan_pwm_freq <= io_req.wdata;
        hfo_pkg::IDX_FAN_CFG: fan_config_one <= io_req.wdata & hfo_pkg::FAN_CFG_MASK;
        // Bit 7 stays writable: in speed mode it is part of the count.
        hfo_pkg::IDX_SYS_TARGET: sys_target_temp_speed <= io_req.wdata;
        hfo_pkg::IDX_CPU_TARGET: cpu_target_temp_speed <= io_req.wdata;
        default: ;
      endcase
    end
  end

  // Output values: strap level after reset, then host writes.
  // The strap load outranks a host write in its one cycle; no host cycle
  // can arrive that early, as the first one follows some cycles later.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sys_fan_output_value <= hfo_pkg::ZERO_BYTE;
      cpu_fan_output_value <= hfo_pkg::ZERO_BYTE;
    end else if (!strap_loaded && strap_s2 == strap_s3) begin
      sys_fan_output_value <= strap_s3;
      cpu_fan_output_value <= strap_s3;
    end else if (data_wr && index_pointer == hfo_pkg::IDX_SYS_VALUE) begin
      sys_fan_output_value <= io_req.wdata;
    end else if (data_wr && index_pointer == hfo_pkg::IDX_CPU_VALUE) begin
      cpu_fan_output_value <= io_req.wdata;
    end
  end

  // Read mux; reserved bits and unimplemented indexes read zero.
  // The mux is built from the index port decode and the pointer; the strobe only gates the capture
  // below, so a missed cycle leaves the last read data standing.
  always_comb begin
    next_rdata = hfo_pkg::ZERO_BYTE;
    if (hit_index) begin
      next_rdata = {1'b0, index_pointer};
    end else begin
      case (index_pointer)
        hfo_pkg::IDX_SYS_FREQ: next_rdata = sys_fan_pwm_freq;
        hfo_pkg::IDX_SYS_VALUE: next_rdata = sys_fan_output_value;
        hfo_pkg::IDX_CPU_FREQ: next_rdata = cpu_fan_pwm_freq;
        hfo_pkg::IDX_CPU_VALUE: next_rdata = cpu_fan_output_value;
        hfo_pkg::IDX_FAN_CFG: next_rdata = fan_config_one & hfo_pkg::FAN_CFG_MASK;
        hfo_pkg::IDX_SYS_TARGET: next_rdata = sys_target_temp_speed;
        hfo_pkg::IDX_CPU_TARGET: next_rdata = cpu_target_temp_speed;
        hfo_pkg::IDX_BANK_SEL: next_rdata = bank;
        default: next_rdata = hfo_pkg::ZERO_BYTE;
      endcase
    end
  end

  // Read data is registered; it is valid the cycle after the read strobe.
  // Registering costs one cycle of latency but keeps the bus output glitch free.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      io_rdata <= hfo_pkg::ZERO_BYTE;
    end else if (io_req.rd && (hit_index || hit_data)) begin
      io_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Mode fields
  // ----------------------------------------------------------------
  // Code 11 is passed through for the system fan but has no function there.
  // The fields are only carried out to the automatic control logic; the
  // drives below run from the output values in every mode.
  assign processor_drive_mode_field =
    hfo_pkg::hfo_mode_t'(fan_config_one[hfo_pkg::CFG_CPU_MODE_LSB +: 2]);
  assign system_drive_mode_field =
    hfo_pkg::hfo_mode_t'(fan_config_one[hfo_pkg::CFG_SYS_MODE_LSB +: 2]);

  // ----------------------------------------------------------------
  // Source clock ticks
  // ----------------------------------------------------------------
  // The 24 MHz and 180 KHz sources are approximated by NCOs on the 25 MHz
  // reference; jitter of one reference cycle is the price of one clock.
  // The error does not build up, so the PWM period is exact in the mean
  // and off by one reference cycle at worst.
  logic [23:0] fast_acc;
  logic [23:0] slow_acc;
  logic fast_tick;
  logic slow_tick;
  logic [24:0] fast_sum;
  logic [24:0] slow_sum;
  assign fast_sum = {1'b0, fast_acc} + {1'b0, hfo_pkg::FAST_INC};
  assign slow_sum = {1'b0, slow_acc} + {1'b0, hfo_pkg::SLOW_INC};

  // Phase accumulators; the carry out is the source tick.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fast_acc <= 24'h000000;
      slow_acc <= 24'h000000;
      fast_tick <= 1'b0;
      slow_tick <= 1'b0;
    end else begin
      fast_acc <= fast_sum[23:0];
      slow_acc <= slow_sum[23:0];
      fast_tick <= fast_sum[24];
      slow_tick <= slow_sum[24];
    end
  end

  // ----------------------------------------------------------------
  // PWM channels
  // ----------------------------------------------------------------
  logic [6:0] sys_pre;
  logic [6:0] cpu_pre;
  logic [7:0] sys_cnt;
  logic [7:0] cpu_cnt;
  logic sys_dc_sel;
  logic cpu_dc_sel;

  // Output type bits, named once so every user agrees on their sense.
  assign sys_dc_sel = fan_config_one[hfo_pkg::CFG_SYS_TYPE_BIT];
  assign cpu_dc_sel = fan_config_one[hfo_pkg::CFG_CPU_TYPE_BIT];

  // True when the prescaler has counted the last source tick of a step.
  // A zero divider wraps on every tick, the same as a divider of one.
  function automatic logic pre_wrap(input logic [6:0] pre, input logic [6:0] div);
    pre_wrap = (pre + 7'h01 >= div);
  endfunction : pre_wrap

  // Selects the source tick from the clock select bit.
  function automatic logic src_tick(input hfo_pkg::hfo_freq_t f, input logic ft,
                                    input logic st);
    src_tick = f.clk_sel ? st : ft;
  endfunction : src_tick

  // Prescaler then 256-step period counter, as one concern per channel.
  // Counters freeze in DC mode, so a return to PWM resumes mid-period.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sys_pre <= 7'h00;
      sys_cnt <= 8'h00;
    end else if (!sys_dc_sel &&
                 src_tick(sys_fan_pwm_freq, fast_tick, slow_tick)) begin
      // A zero prescaler behaves as one; software must not use it.
      if (pre_wrap(sys_pre, sys_fan_pwm_freq.prescale)) begin
        sys_pre <= 7'h00;
        sys_cnt <= sys_cnt + 8'h01;
      end else begin
        sys_pre <= sys_pre + 7'h01;
      end
    end
  end

  // Same structure for the CPU channel.
  // It shares the source ticks, so both channels stay in step on one source.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cpu_pre <= 7'h00;
      cpu_cnt <= 8'h00;
    end else if (!cpu_dc_sel &&
                 src_tick(cpu_fan_pwm_freq, fast_tick, slow_tick)) begin
      if (pre_wrap(cpu_pre, cpu_fan_pwm_freq.prescale)) begin
        cpu_pre <= 7'h00;
        cpu_cnt <= cpu_cnt + 8'h01;
      end else begin
        cpu_pre <= cpu_pre + 7'h01;
      end
    end
  end

  // Duty of value/255: high while count < value, FFh forced fully high.
  // Values below FFh give value/256, within half a percent of value/255.
  function automatic logic duty_high(input logic [7:0] cnt, input logic [7:0] val);
    duty_high = (val == 8'hff) || (cnt < val && cnt <= hfo_pkg::PWM_TOP);
  endfunction : duty_high

  // Registered drive outputs; in DC mode the pin carries no PWM wave.
  // DC levels keep only the upper six bits; the two low bits are reserved.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      system_fan_drive <= 1'b0;
      processor_fan_drive <= 1'b0;
      system_fan_dc_level <= 6'h00;
      processor_fan_dc_level <= 6'h00;
      system_drive_is_dc <= 1'b1;
      processor_drive_is_dc <= 1'b0;
    end else begin
      system_drive_is_dc <= sys_dc_sel;
      processor_drive_is_dc <= cpu_dc_sel;
      system_fan_drive <= !sys_dc_sel &&
                          duty_high(sys_cnt, sys_fan_output_value);
      processor_fan_drive <= !cpu_dc_sel &&
                             duty_high(cpu_cnt, cpu_fan_output_value);
      system_fan_dc_level <= sys_dc_sel ?
        sys_fan_output_value[7:hfo_pkg::DC_VALUE_LSB] : 6'h00;
      processor_fan_dc_level <= cpu_dc_sel ?
        cpu_fan_output_value[7:hfo_pkg::DC_VALUE_LSB] : 6'h00;
    end
  end

endmodule : hfo_fan_regs

// ===== shared/hfo_pkg.sv
// Constants, field layouts and carrier types for the fan output register block.
// Assumes a single 25 MHz clock domain and host I/O cycles presented as strobes.
package hfo_pkg;

  // ----------------------------------------------------------------
  // Host port decode
  // ----------------------------------------------------------------
  localparam logic [15:0] PORT_INDEX_OFS = 16'h0005;
  localparam logic [15:0] PORT_DATA_OFS = 16'h0006;

  // ----------------------------------------------------------------
  // Register indexes
  // ----------------------------------------------------------------
  localparam logic [6:0] IDX_SYS_FREQ = 7'h00;
  localparam logic [6:0] IDX_SYS_VALUE = 7'h01;
  localparam logic [6:0] IDX_CPU_FREQ = 7'h02;
  localparam logic [6:0] IDX_CPU_VALUE = 7'h03;
  localparam logic [6:0] IDX_FAN_CFG = 7'h04;
  localparam logic [6:0] IDX_SYS_TARGET = 7'h05;
  localparam logic [6:0] IDX_CPU_TARGET = 7'h06;
  localparam logic [6:0] IDX_BANK_SEL = 7'h4e;
  localparam logic [6:0] IDX_GLOBAL_LAST = 7'h4f;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] FREQ_RESET = 8'h04;
  localparam logic [7:0] FAN_CFG_RESET = 8'h01;
  localparam logic [7:0] FAN_CFG_MASK = 8'h3f;
  localparam logic [7:0] INDEX_MASK = 8'h7f;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] BANK_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FREQ_CLK_SEL_BIT = 7;
  localparam int CFG_CPU_TYPE_BIT = 1;
  localparam int CFG_SYS_TYPE_BIT = 0;
  localparam int CFG_CPU_MODE_LSB = 4;
  localparam int CFG_SYS_MODE_LSB = 2;
  localparam int DC_VALUE_LSB = 2;

  // ----------------------------------------------------------------
  // Timing: source clocks synthesised from the 25 MHz reference
  // ----------------------------------------------------------------
  localparam int REF_CLK_HZ = 25000000;
  localparam int FAST_SRC_HZ = 24000000;
  localparam int SLOW_SRC_HZ = 180000;
  // Phase accumulator increments for a 24-bit NCO.
  localparam logic [23:0] FAST_INC =
    24'((64'(FAST_SRC_HZ) << 24) / 64'(REF_CLK_HZ));
  localparam logic [23:0] SLOW_INC =
    24'((64'(SLOW_SRC_HZ) << 24) / 64'(REF_CLK_HZ));
  localparam logic [7:0] PWM_TOP = 8'hfe;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HFO_MODE_MANUAL = 2'h0,
    HFO_MODE_THERMAL = 2'h1,
    HFO_MODE_SPEED = 2'h2,
    HFO_MODE_AUTO = 2'h3
  } hfo_mode_t;

  typedef struct packed {
    logic clk_sel;
    logic [6:0] prescale;
  } hfo_freq_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } hfo_io_req_t;

  typedef struct packed {
    logic dc_mode;
    logic pwm;
    logic [5:0] dc_level;
  } hfo_drive_t;

endpackage : hfo_pkg

// ===== test/hfo_fan_regs_sva.sv
// Checker for the fan output register block, bound to its top module.
// Assumes one clock domain and host strobes that last one cycle.
`timescale 1ns/1ns
module hfo_fan_regs_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Host side
  input wire logic [7:0] base_high_byte_cfg,
  input wire logic [7:0] base_low_byte_cfg,
  input wire hfo_pkg::hfo_io_req_t io_req,
  input wire logic io_hit,
  input wire logic [7:0] io_rdata,
  // Drive side
  input wire logic system_fan_drive,
  input wire logic [5:0] processor_fan_dc_level,
  input wire logic system_drive_is_dc,
  input wire logic processor_drive_is_dc,
  input wire hfo_pkg::hfo_mode_t system_drive_mode_field,
  input wire hfo_pkg::hfo_mode_t processor_drive_mode_field,
  input wire logic [7:0] bank_select
);
  logic [15:0] base;
  logic at_ptr;
  logic at_data;
  logic wr_cfg;
  logic [6:0] ptr;
  // Own decode, so that a wrong decode in the block cannot hide itself.
  assign base = {base_high_byte_cfg, base_low_byte_cfg};
  assign at_ptr = io_req.addr == base + hfo_pkg::PORT_INDEX_OFS;
  assign at_data = io_req.addr == base + hfo_pkg::PORT_DATA_OFS;
  assign wr_cfg = io_req.wr && at_data && ptr == hfo_pkg::IDX_FAN_CFG;
  // Shadow of the pointer as the host last wrote it.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ptr <= 7'h00;
    end else if (io_req.wr && at_ptr) begin
      ptr <= io_req.wdata[6:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_hit_decode: assert property (
    io_hit == ((io_req.rd || io_req.wr) && (at_ptr || at_data)))
    else $error("io_hit disagrees with the port decode");
  chk_rdata_hold: assert property (!(io_req.rd && io_hit) |=> $stable(io_rdata))
    else $error("read data moved without a hitting read");
  chk_ptr_read: assert property (io_req.rd && at_ptr |=> io_rdata == {1'b0, $past(ptr)})
    else $error("index port read is not the 7-bit pointer");
  chk_bank_write: assert property (
    io_req.wr && at_data && ptr == hfo_pkg::IDX_BANK_SEL |=> bank_select == $past(io_req.wdata))
    else $error("bank select did not take the written value");
  chk_cfg_mode: assert property (wr_cfg |=> system_drive_mode_field == $past(io_req.wdata[3:2])
    && processor_drive_mode_field == $past(io_req.wdata[5:4]))
    else $error("mode fields do not follow the configuration write");
  chk_cfg_type: assert property (wr_cfg |-> ##2 system_drive_is_dc == $past(io_req.wdata[0], 2)
    && processor_drive_is_dc == $past(io_req.wdata[1], 2))
    else $error("output type does not follow the configuration write");
  chk_dc_quiet: assert property (
    system_drive_is_dc && $past(system_drive_is_dc) |-> !system_fan_drive)
    else $error("system drive pulses while in DC mode");
  chk_pwm_level: assert property (
    !processor_drive_is_dc && $past(!processor_drive_is_dc) |-> processor_fan_dc_level == 6'h00)
    else $error("processor DC level set while in PWM mode");
  chk_reset_vals: assert property ($fell(reset) |-> io_rdata == 8'h00 && system_drive_is_dc
    && !processor_drive_is_dc && bank_select == 8'h00)
    else $error("outputs not at their reset values");
endmodule : hfo_fan_regs_sva

bind hfo_fan_regs hfo_fan_regs_sva i_sva (.ref_clk, .reset, .base_high_byte_cfg,
  .base_low_byte_cfg, .io_req, .io_hit, .io_rdata, .system_fan_drive, .processor_fan_dc_level,
  .system_drive_is_dc, .processor_drive_is_dc, .system_drive_mode_field,
  .processor_drive_mode_field, .bank_select);

// ===== test/hfo_host.sv
// Host model that issues I/O cycles to the index and data ports.
// Assumes strobes are driven on the falling edge and last one cycle.
`timescale 1ns/1ns
module hfo_host (
  // Clock and port base
  input wire logic ref_clk,
  input wire logic [15:0] base,
  // I/O cycle
  output hfo_pkg::hfo_io_req_t io_req,
  input wire logic [7:0] io_rdata
);
  // Released address and data show the inverse, so stale values never look valid.
  initial io_req = '0;
  task automatic io_cyc(input logic rd, input logic [15:0] a, input logic [7:0] v,
                        output logic [7:0] d);
    @(negedge ref_clk);
    io_req = '{rd: rd, wr: !rd, addr: a, wdata: v};
    @(negedge ref_clk);
    io_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~v};
    d = io_rdata;
  endtask : io_cyc
  // Pointer first, then data; bit 7 of the pointer is set to prove it is dropped.
  task automatic reg_acc(input logic rd, input logic [6:0] i, input logic [7:0] v,
                         output logic [7:0] d);
    io_cyc(1'b0, base + hfo_pkg::PORT_INDEX_OFS, {1'b1, i}, d);
    io_cyc(rd, base + hfo_pkg::PORT_DATA_OFS, v, d);
  endtask : reg_acc
endmodule : hfo_host

// ===== test/tb.sv
// Self-checking bench for the fan output register block.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ns
module tb;
  logic ref_clk, reset, sys_drv, cpu_drv, sys_dc, cpu_dc, io_hit;
  logic [7:0] base_hi, base_lo, strap, d, v, bank;
  logic [15:0] old;
  logic [5:0] sys_lvl, cpu_lvl;
  logic [6:0] i;
  hfo_pkg::hfo_io_req_t io_req;
  logic [7:0] io_rdata;
  hfo_pkg::hfo_mode_t sys_mode, cpu_mode;
  int fails, checks_done, n, hs, hc;
  longint e;
  logic [6:0] idx_tab [8] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h4e};

  hfo_fan_regs i_dut (.ref_clk(ref_clk), .reset(reset), .base_high_byte_cfg(base_hi),
    .base_low_byte_cfg(base_lo), .io_req(io_req), .io_hit(io_hit), .io_rdata(io_rdata),
    .fan_set_strap(strap), .system_fan_drive(sys_drv), .processor_fan_drive(cpu_drv),
    .system_fan_dc_level(sys_lvl), .processor_fan_dc_level(cpu_lvl),
    .system_drive_is_dc(sys_dc), .processor_drive_is_dc(cpu_dc),
    .system_drive_mode_field(sys_mode), .processor_drive_mode_field(cpu_mode),
    .bank_select(bank));
  hfo_host i_host (.ref_clk(ref_clk), .base({base_hi, base_lo}), .io_req(io_req),
    .io_rdata(io_rdata));

  // ----
  // Checking helpers
  // ----
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  function automatic logic [7:0] rst_exp(input logic [6:0] x);
    case (x)
      hfo_pkg::IDX_SYS_FREQ, hfo_pkg::IDX_CPU_FREQ: return hfo_pkg::FREQ_RESET;
      hfo_pkg::IDX_SYS_VALUE, hfo_pkg::IDX_CPU_VALUE: return strap;
      hfo_pkg::IDX_FAN_CFG: return hfo_pkg::FAN_CFG_RESET;
      default: return hfo_pkg::ZERO_BYTE;
    endcase
  endfunction : rst_exp
  // Unimplemented places read zero, so a write there must not stick.
  function automatic logic [7:0] wr_exp(input logic [6:0] x, input logic [7:0] y);
    if (x == hfo_pkg::IDX_FAN_CFG) return y & hfo_pkg::FAN_CFG_MASK;
    if (x <= hfo_pkg::IDX_CPU_TARGET || x == hfo_pkg::IDX_BANK_SEL) return y;
    return hfo_pkg::ZERO_BYTE;
  endfunction : wr_exp
  // Reset, wait the settling edges, then compare every reset value.
  task automatic do_reset();
    reset = 1'b1;
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    repeat (4) @(negedge ref_clk);
    i_host.io_cyc(1'b1, {base_hi, base_lo} + hfo_pkg::PORT_INDEX_OFS, 8'h00, d);
    check(d, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      i_host.reg_acc(1'b1, idx_tab[k], 8'h00, d);
      check(d, rst_exp(idx_tab[k]));
    end
  endtask : do_reset
  task automatic count_high(input int len);
    hs = 0;
    hc = 0;
    repeat (len) begin
      @(negedge ref_clk);
      hs += int'(sys_drv === 1'b1);
      hc += int'(cpu_drv === 1'b1);
    end
  endtask : count_high
  // Length of one high phase of the system drive, bounded against a stuck pin.
  task automatic high_time();
    hs = 0;
    n = 0;
    while (sys_drv !== 1'b0 && n < 80000) begin @(negedge ref_clk); n++; end
    while (sys_drv !== 1'b1 && n < 80000) begin @(negedge ref_clk); n++; end
    while (sys_drv === 1'b1 && n < 80000) begin @(negedge ref_clk); n++; hs++; end
  endtask : high_time

  // ----
  // Clock, watchdog and main sequence
  // ----
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #3600000;
    fails++;
    test_done();
  end
  initial begin
    fails = 0;
    checks_done = 0;
    void'($urandom(32'h1ca4c644));
    reset = 1'b1;
    base_hi = 8'h02;
    base_lo = 8'h90;
    strap = 8'($urandom);
    do_reset();
    // Random traffic over the known registers first, then 20 random pointer values.
    for (int k = 0; k < 28; k++) begin
      i = (k < 8) ? idx_tab[k] : 7'($urandom);
      v = 8'($urandom);
      if (i == hfo_pkg::IDX_SYS_FREQ || i == hfo_pkg::IDX_CPU_FREQ) v[6:0] = 7'd1 + 7'(v % 127);
      i_host.reg_acc(1'b0, i, v, d);
      i_host.reg_acc(1'b1, i, 8'h00, d);
      check(d, wr_exp(i, v));
      i_host.io_cyc(1'b1, {base_hi, base_lo} + hfo_pkg::PORT_INDEX_OFS, 8'h00, d);
      check(d, {1'b0, i});
    end
    // Misses leave read data alone; moving the base moves both ports.
    v = 8'($urandom);
    i_host.reg_acc(1'b0, hfo_pkg::IDX_SYS_TARGET, v, d);
    i_host.reg_acc(1'b1, hfo_pkg::IDX_SYS_TARGET, 8'h00, d);
    i_host.io_cyc(1'b1, {base_hi, base_lo} + 16'h0007, 8'h00, d);
    check(d, v);
    old = {base_hi, base_lo};
    base_hi = base_hi ^ 8'h80;
    base_lo = 8'($urandom);
    i_host.io_cyc(1'b0, old + hfo_pkg::PORT_DATA_OFS, ~v, d);
    i_host.reg_acc(1'b1, hfo_pkg::IDX_SYS_TARGET, 8'h00, d);
    check(d, v);
    i_host.reg_acc(1'b0, hfo_pkg::IDX_BANK_SEL, ~v, d);
    check({8'h00, bank}, {8'h00, ~v});
    i_host.reg_acc(1'b1, hfo_pkg::IDX_SYS_TARGET, 8'h00, d);
    check(d, v);
    // Every mode code on both fields.
    for (int m = 0; m < 4; m++) begin
      i_host.reg_acc(1'b0, hfo_pkg::IDX_FAN_CFG, {2'h0, 2'(m), ~2'(m), 2'h0}, d);
      check({sys_mode, cpu_mode}, {~2'(m), 2'(m)});
    end
    // Duty extremes on both drives in PWM mode.
    i_host.reg_acc(1'b0, hfo_pkg::IDX_SYS_FREQ, 8'h01, d);
    i_host.reg_acc(1'b0, hfo_pkg::IDX_CPU_FREQ, 8'h01, d);
    for (int k = 0; k < 2; k++) begin
      i_host.reg_acc(1'b0, hfo_pkg::IDX_SYS_VALUE, k ? 8'h00 : 8'hff, d);
      i_host.reg_acc(1'b0, hfo_pkg::IDX_CPU_VALUE, k ? 8'h00 : 8'hff, d);
      repeat (4) @(negedge ref_clk);
      count_high(600);
      check({16'(hs)}, k ? 16'd0 : 16'd600);
      check({16'(hc)}, k ? 16'd0 : 16'd600);
    end
    // High phase length follows value, prescaler and source clock.
    for (int k = 0; k < 2; k++) begin
      i_host.reg_acc(1'b0, hfo_pkg::IDX_SYS_FREQ, k ? 8'h81 : 8'h03, d);
      i_host.reg_acc(1'b0, hfo_pkg::IDX_SYS_VALUE, k ? 8'h20 : 8'h40, d);
      e = k ? 32 * longint'(hfo_pkg::REF_CLK_HZ) / hfo_pkg::SLOW_SRC_HZ
            : 192 * longint'(hfo_pkg::REF_CLK_HZ) / hfo_pkg::FAST_SRC_HZ;
      high_time();
      check(16'(hs > e * 97 / 100 && hs < e * 103 / 100), 16'h0001);
    end
    // DC mode: level is value over 4, pin quiet, frequency writes have no effect.
    i_host.reg_acc(1'b0, hfo_pkg::IDX_FAN_CFG, 8'h03, d);
    v = 8'($urandom);
    i_host.reg_acc(1'b0, hfo_pkg::IDX_SYS_VALUE, v, d);
    i_host.reg_acc(1'b0, hfo_pkg::IDX_CPU_VALUE, ~v, d);
    for (int k = 0; k < 2; k++) begin
      repeat (4) @(negedge ref_clk);
      count_high(300);
      check({sys_lvl, cpu_lvl}, {v[7:2], ~v[7:2]});
      check(16'(hs + hc), 16'd0);
      i_host.reg_acc(1'b0, hfo_pkg::IDX_SYS_FREQ, 8'h85, d);
    end
    // Second reset with a new strap level.
    strap = 8'($urandom);
    repeat (4) @(negedge ref_clk);
    do_reset();
    test_done();
  end
endmodule : tb
